// *** src/tss_time_sync_supervisor.sv ***
// Purpose: Keep the internal time of day aligned to an external source
// Assumes: Source decoders deliver one-cycle time strobes; inputs synchronous
// Notes: Date stays day-of-month only; months are taken as 31 days long
//
// Function
// - Radio time ignored until decoded after restart
// - Time code year taken from set value
// - Pulse above 30 s: next minute, 00
// - Pulse below 30 s: clear seconds only
// - Pulse acts immediately, unchecked, except while a source switch settles
// - Add signed offset up to 1439 minutes
// - Alarm when no sync within tolerance
// - Source change within one second, unsynced
// - Offset change, or time code year change, jumps while synced; paired messages
// - Interruption on after gap or source change
// - Interruption on stamped with old time; on an offset or year jump, old time less old offset
// - Interruption off once sync regained
// - Interruption off stamped with new time
// - Select day-first or month-first date format
// - Only selected source; free run on failure
// - Power-up loads time from battery RTC
`timescale 1ns/1ns
module tss_time_sync_supervisor #(
	parameter int unsigned TICK_CYCLES = tss_pkg::TICK_CYCLES,
	parameter int unsigned SWITCH_CYCLES = tss_pkg::SWITCH_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire tss_pkg::tss_time_s rtc_time,
	input wire tss_pkg::tss_src_e src_sel,
	input wire logic radio_valid,
	input wire tss_pkg::tss_time_s radio_time,
	input wire logic irig_valid,
	input wire tss_pkg::tss_time_s irig_time,
	input wire logic [6:0] irig_year,
	input wire logic minute_pulse,
	input wire logic offset_neg,
	input wire logic [10:0] offset_min,
	input wire logic [15:0] tol_s,
	input wire logic us_format,
	output tss_pkg::tss_time_s now_time,
	output logic synced,
	output logic sync_fault,
	output logic intr_on,
	output logic intr_off,
	output tss_pkg::tss_time_s intr_stamp,
	output logic date_us
);
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic tss_pkg::tss_time_s add_minutes(input tss_pkg::tss_time_s t,
		input logic neg, input logic [10:0] m);
		logic [12:0] mod;
		logic [12:0] total;
		tss_pkg::tss_time_s r;
		r = t;
		mod = 13'({t.hour, 6'h00}) - 13'({2'h0, t.hour, 2'h0}) + 13'(t.minute);
		if (neg) begin
			total = mod + 13'(tss_pkg::MIN_PER_DAY) - 13'(m);
		end else begin
			total = mod + 13'(m);
		end
		if (total >= 13'(tss_pkg::MIN_PER_DAY)) begin
			total = total - 13'(tss_pkg::MIN_PER_DAY);
		end
		r.hour = 5'(total / 13'h003C);
		r.minute = 6'(total % 13'h003C);
		return r;
	endfunction : add_minutes

	function automatic tss_pkg::tss_time_s next_min(input tss_pkg::tss_time_s t);
		tss_pkg::tss_time_s r;
		r = t;
		r.second = 6'h00;
		if (t.minute == 6'h3B) begin
			r.minute = 6'h00;
			if (t.hour == 5'h17) begin
				r.hour = 5'h00;
				r.day = (t.day == 5'h1F) ? 5'h01 : t.day + 5'h01;
			end else begin
				r.hour = t.hour + 5'h01;
			end
		end else begin
			r.minute = t.minute + 6'h01;
		end
		return r;
	endfunction : next_min

	// ----------------------------------------------------------------
	// Tick and source bookkeeping
	// ----------------------------------------------------------------
	logic [31:0] tick_cnt;
	logic tick;
	logic [31:0] switch_cnt;
	tss_pkg::tss_src_e src_act;
	tss_pkg::tss_src_e src_prev;
	logic switching;
	logic [15:0] gap_s;
	logic [7:0] decode_s;
	tss_pkg::tss_state_e state;
	logic [10:0] off_prev;
	logic offneg_prev;
	logic [6:0] year_prev;
	logic [10:0] off_eff;
	logic [15:0] tol_eff;
	logic sync_ev;
	tss_pkg::tss_time_s sync_val;
	tss_pkg::tss_time_s raw_val;
	logic cfg_jump;

	assign tick = (tick_cnt == TICK_CYCLES - 1);
	// Out-of-range offsets are clamped rather than wrapping the day twice
	assign off_eff = (offset_min > tss_pkg::OFFSET_MAX) ? tss_pkg::OFFSET_MAX : offset_min;
	// Short tolerances are raised to the floor the source cadence needs
	assign tol_eff = (tol_s < tss_pkg::TOL_MIN_S) ? tss_pkg::TOL_MIN_S : tol_s;
	assign cfg_jump = (state == tss_pkg::TSS_ST_SYNC) && ((off_eff != off_prev) ||
		(offset_neg != offneg_prev) ||
		((src_act == tss_pkg::TSS_SRC_IRIG) && (irig_year != year_prev)));

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tick_cnt <= 32'h0000_0000;
		end else if (tick) begin
			tick_cnt <= 32'h0000_0000;
		end else begin
			tick_cnt <= tick_cnt + 32'h0000_0001;
		end
	end

	// Source change: old source dropped at once, new one taken after settle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			src_prev <= tss_pkg::TSS_SRC_INTERNAL;
			src_act <= tss_pkg::TSS_SRC_INTERNAL;
			switching <= 1'b0;
			switch_cnt <= 32'h0000_0000;
		end else begin
			src_prev <= src_sel;
			if (src_sel != src_prev) begin
				switching <= 1'b1;
				switch_cnt <= 32'h0000_0000;
			end else if (switching) begin
				if (switch_cnt == SWITCH_CYCLES - 1) begin
					switching <= 1'b0;
					src_act <= src_sel;
				end else begin
					switch_cnt <= switch_cnt + 32'h0000_0001;
				end
			end
		end
	end

	// Decode hold-off for radio after start-up or source switch
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			decode_s <= 8'h00;
		end else if (switching || (state != tss_pkg::TSS_ST_SYNC && gap_s == 16'h0000)) begin
			decode_s <= 8'h00;
		end else if (tick && decode_s < 8'(tss_pkg::RADIO_DECODE_S)) begin
			decode_s <= decode_s + 8'h01;
		end
	end

	// Only the active source may synchronize; others are ignored
	always_comb begin
		sync_ev = 1'b0;
		raw_val = now_time;
		if (!switching) begin
			case (src_act)
				tss_pkg::TSS_SRC_RADIO: begin
					sync_ev = radio_valid && (decode_s >= 8'(tss_pkg::RADIO_DECODE_S));
					raw_val = radio_time;
				end
				tss_pkg::TSS_SRC_IRIG: begin
					sync_ev = irig_valid;
					raw_val = irig_time;
					raw_val.year = irig_year;
				end
				tss_pkg::TSS_SRC_PULSE: begin
					sync_ev = minute_pulse;
					if (now_time.second > tss_pkg::SEC_HALF) begin
						raw_val = next_min(now_time);
					end else begin
						raw_val.second = 6'h00;
					end
				end
				default: begin
					sync_ev = 1'b0;
				end
			endcase
		end
		if (src_act == tss_pkg::TSS_SRC_PULSE) begin
			sync_val = raw_val;
		end else begin
			sync_val = add_minutes(raw_val, offset_neg, off_eff);
		end
	end

	// ----------------------------------------------------------------
	// Time of day
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			now_time <= '0;
			now_time.year <= tss_pkg::RESET_YEAR;
		end else if (state == tss_pkg::TSS_ST_LOAD) begin
			now_time <= rtc_time;
		end else if (sync_ev) begin
			now_time <= sync_val;
		end else if (cfg_jump) begin
			now_time <= add_minutes(add_minutes(now_time, ~offneg_prev, off_prev),
				offset_neg, off_eff);
			if (src_act == tss_pkg::TSS_SRC_IRIG) begin
				now_time.year <= irig_year;
			end
		end else if (tick) begin
			if (now_time.second == 6'h3B) begin
				now_time <= next_min(now_time);
			end else begin
				now_time.second <= now_time.second + 6'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// Supervision and messages
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= tss_pkg::TSS_ST_LOAD;
			gap_s <= 16'h0000;
			sync_fault <= 1'b0;
			synced <= 1'b0;
			intr_on <= 1'b0;
			intr_off <= 1'b0;
			intr_stamp <= '0;
			off_prev <= 11'h000;
			offneg_prev <= 1'b0;
			year_prev <= tss_pkg::RESET_YEAR;
		end else begin
			intr_on <= 1'b0;
			intr_off <= 1'b0;
			off_prev <= off_eff;
			offneg_prev <= offset_neg;
			year_prev <= irig_year;
			case (state)
				tss_pkg::TSS_ST_LOAD: begin
					// Start unsynced so every source, internal too, reports regained sync
					state <= tss_pkg::TSS_ST_UNSYNC;
				end
				tss_pkg::TSS_ST_UNSYNC: begin
					if (switching) begin
						gap_s <= 16'h0000;
						// Counter is zero only in the first cycle after a change
						if (switch_cnt == 32'h0000_0000) begin
							intr_on <= 1'b1;
							intr_stamp <= now_time;
						end
					end else if (src_act == tss_pkg::TSS_SRC_INTERNAL) begin
						state <= tss_pkg::TSS_ST_SYNC;
						gap_s <= 16'h0000;
						sync_fault <= 1'b0;
						intr_off <= 1'b1;
						intr_stamp <= now_time;
					end else if (sync_ev) begin
						state <= tss_pkg::TSS_ST_SYNC;
						gap_s <= 16'h0000;
						sync_fault <= 1'b0;
						intr_off <= 1'b1;
						intr_stamp <= sync_val;
					end else if (tick && gap_s != 16'hFFFF) begin
						gap_s <= gap_s + 16'h0001;
						if (gap_s >= tol_eff) begin
							sync_fault <= 1'b1;
						end
					end
				end
				default: begin
					if (switching) begin
						state <= tss_pkg::TSS_ST_UNSYNC;
						gap_s <= 16'h0000;
						intr_on <= 1'b1;
						intr_stamp <= now_time;
					end else if (cfg_jump) begin
						intr_on <= 1'b1;
						intr_stamp <= add_minutes(now_time, ~offneg_prev, off_prev);
						intr_off <= 1'b0;
					end else if (sync_ev) begin
						gap_s <= 16'h0000;
					end else if (tick && src_act != tss_pkg::TSS_SRC_INTERNAL) begin
						gap_s <= gap_s + 16'h0001;
						if (gap_s >= tol_eff) begin
							state <= tss_pkg::TSS_ST_UNSYNC;
							sync_fault <= 1'b1;
							intr_on <= 1'b1;
							intr_stamp <= now_time;
						end
					end
					if (intr_on && !switching && state == tss_pkg::TSS_ST_SYNC &&
						!cfg_jump && off_prev == off_eff) begin
						intr_off <= 1'b1;
						intr_stamp <= now_time;
					end
				end
			endcase
			synced <= (state == tss_pkg::TSS_ST_SYNC);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			date_us <= 1'b0;
		end else begin
			date_us <= us_format;
		end
	end
endmodule : tss_time_sync_supervisor

// *** src/tss_pkg.sv ***
// Purpose: Shared constants and types for the time sync supervisor
// Assumes: 100 MHz system clock
// Notes: Time stamps travel as tss_time_s
package tss_pkg;
	localparam int unsigned CLK_HZ = 100000000;
	localparam int unsigned TICK_CYCLES = CLK_HZ;
	localparam int unsigned SWITCH_TIME_MS = 1000;
	localparam int unsigned SWITCH_CYCLES = SWITCH_TIME_MS * (CLK_HZ / 1000);
	localparam int unsigned RADIO_DECODE_S = 180;
	localparam logic [5:0] SEC_HALF = 6'h1E;
	localparam logic [10:0] OFFSET_MAX = 11'h59F;
	localparam logic [11:0] MIN_PER_DAY = 12'h5A0;
	localparam logic [15:0] TOL_MIN_S = 16'h0078;
	localparam logic [6:0] RESET_YEAR = 7'h00;

	typedef enum logic [1:0] {
		TSS_SRC_INTERNAL = 2'b00,
		TSS_SRC_RADIO = 2'b01,
		TSS_SRC_IRIG = 2'b10,
		TSS_SRC_PULSE = 2'b11
	} tss_src_e;

	typedef enum logic [1:0] {
		TSS_ST_LOAD = 2'b00,
		TSS_ST_UNSYNC = 2'b01,
		TSS_ST_SYNC = 2'b10
	} tss_state_e;

	typedef struct packed {
		logic [6:0] year;
		logic [3:0] month;
		logic [4:0] day;
		logic [4:0] hour;
		logic [5:0] minute;
		logic [5:0] second;
	} tss_time_s;
endpackage : tss_pkg

// *** test/tss_sva.sv ***
// Purpose: Port assertions for the time sync supervisor
// Assumes: SWITCH_CYCLES matches the bound instance
// Notes: Pulse checks hold off until a source change has settled
`timescale 1ns/1ns
module tss_sva #(
	parameter int unsigned SWITCH_CYCLES = 5
) (
	input wire logic clk,
	input wire logic rst,
	input wire tss_pkg::tss_src_e src_sel,
	input wire logic minute_pulse,
	input wire logic [10:0] offset_min,
	input wire logic us_format,
	input wire tss_pkg::tss_time_s now_time,
	input wire logic synced,
	input wire logic intr_on,
	input wire logic intr_off,
	input wire tss_pkg::tss_time_s intr_stamp,
	input wire logic date_us
);
	localparam int SW_WIN = SWITCH_CYCLES + 4;
	logic [7:0] quiet;
	logic settled;
	// Strobes are refused while a switch settles, so no claim is made then
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			// Reset counts as a source change: with a source other than internal selected, the design settles again after it
			quiet <= 8'h00;
		end else if ($changed(src_sel)) begin
			quiet <= 8'h00;
		end else if (quiet != 8'hFF) begin
			quiet <= quiet + 8'h01;
		end
	end
	assign settled = quiet > 8'(SWITCH_CYCLES + 2);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_jump_pair;
		intr_on ##1 intr_off;
	endsequence
	sequence s_pulse_take;
		settled && src_sel == tss_pkg::TSS_SRC_PULSE && minute_pulse && now_time.minute < 6'h3B;
	endsequence
	chk_on_single: assert property (intr_on |=> !intr_on)
		else $error("interruption on longer than one cycle");
	chk_off_single: assert property (intr_off |=> !intr_off)
		else $error("interruption off longer than one cycle");
	chk_on_off_apart: assert property (!(intr_on && intr_off))
		else $error("both interruption messages at once");
	chk_pulse_late: assert property (s_pulse_take ##0 now_time.second > 6'h1E |=>
		now_time.second == 6'h00 && now_time.minute == $past(now_time.minute) + 6'h01)
		else $error("late pulse did not move to next minute");
	chk_pulse_early: assert property (s_pulse_take ##0 now_time.second <= 6'h1E |=>
		now_time.second == 6'h00 && now_time.minute == $past(now_time.minute))
		else $error("early pulse did not clear seconds");
	chk_fmt_follow: assert property ($changed(us_format) |=> date_us == $past(us_format))
		else $error("date format not followed");
	chk_stamp_hold: assert property (!intr_on && !intr_off |-> $stable(intr_stamp))
		else $error("stamp changed without a message");
	chk_switch_on: assert property (settled && $changed(src_sel) |-> ##[1:SW_WIN] intr_on)
		else $error("no interruption on after source change");
	chk_jump_pair: assert property (settled && synced && $changed(offset_min) &&
		src_sel == tss_pkg::TSS_SRC_RADIO |-> ##[1:4] s_jump_pair)
		else $error("offset change without paired messages");
	chk_sync_off: assert property ($rose(synced) |->
		intr_off || $past(intr_off) || $past(intr_off, 2))
		else $error("sync regained without interruption off");
endmodule : tss_sva

// *** test/tss_src_model.sv ***
// Purpose: Far-side model of radio decoder, time code decoder and minute pulse
// Assumes: Each source hands over one-cycle strobes
// Notes: Released time buses show the inverse so stale values never pass
`timescale 1ns/1ns
module tss_src_model (
	input wire logic clk,
	output logic radio_valid,
	output tss_pkg::tss_time_s radio_time,
	output logic irig_valid,
	output tss_pkg::tss_time_s irig_time,
	output logic minute_pulse
);
	initial begin
		radio_valid = 1'b0;
		irig_valid = 1'b0;
		minute_pulse = 1'b0;
		radio_time = '0;
		irig_time = '0;
	end
	// Kind 0 radio, 1 time code, 2 pulse; returns just after the taking edge
	task automatic send(input int kind, input tss_pkg::tss_time_s t);
		@(posedge clk);
		#1;
		radio_time = t;
		irig_time = t;
		radio_valid = (kind == 0);
		irig_valid = (kind == 1);
		minute_pulse = (kind == 2);
		@(posedge clk);
		#1;
		radio_valid = 1'b0;
		irig_valid = 1'b0;
		minute_pulse = 1'b0;
		radio_time = ~t;
		irig_time = ~t;
	endtask : send
endmodule : tss_src_model

// *** test/tb_top.sv ***
// Purpose: Self-checking bench for the time sync supervisor
// Assumes: Short tick and settle counts so the hold-offs fit a short run
// Notes: Expected times are built from fields set here, never read back
`timescale 1ns/1ns
module tb_top;
	localparam int TICK = 10;
	localparam int SETTLE = 5;
	logic clk, rst, radio_valid, irig_valid, minute_pulse, offset_neg, us_format, hit;
	logic synced, sync_fault, intr_on, intr_off, date_us;
	tss_pkg::tss_time_s rtc_time, radio_time, irig_time, now_time, intr_stamp, exp_t;
	tss_pkg::tss_src_e src_sel;
	logic [6:0] irig_year;
	logic [10:0] offset_min;
	logic [15:0] tol_s;
	int n_mismatch = 0;
	int checked = 0;
	tss_time_sync_supervisor #(.TICK_CYCLES(TICK), .SWITCH_CYCLES(SETTLE)) dut_u (
		.clk(clk), .rst(rst), .rtc_time(rtc_time), .src_sel(src_sel),
		.radio_valid(radio_valid), .radio_time(radio_time), .irig_valid(irig_valid),
		.irig_time(irig_time), .irig_year(irig_year), .minute_pulse(minute_pulse),
		.offset_neg(offset_neg), .offset_min(offset_min), .tol_s(tol_s),
		.us_format(us_format), .now_time(now_time), .synced(synced),
		.sync_fault(sync_fault), .intr_on(intr_on), .intr_off(intr_off),
		.intr_stamp(intr_stamp), .date_us(date_us));
	tss_src_model src_u (.clk(clk), .radio_valid(radio_valid), .radio_time(radio_time),
		.irig_valid(irig_valid), .irig_time(irig_time), .minute_pulse(minute_pulse));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wait_msg(input logic off, input int lim);
		hit = 1'b0;
		repeat (lim) begin
			if ((off ? intr_off : intr_on) === 1'b1) begin
				hit = 1'b1;
				break;
			end
			cyc(1);
		end
	endtask : wait_msg
	task automatic results();
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : results
	task automatic t_rtc_pulse();
		exp_t = rtc_time;
		check(now_time, exp_t);
		// Reset starts a source settle; pulses before its end are refused
		cyc(SETTLE + 3);
		src_u.send(2, exp_t);
		exp_t.minute = 6'h06;
		exp_t.second = 6'h00;
		check(now_time, exp_t);
		cyc(3 * TICK);
		src_u.send(2, exp_t);
		check(now_time, exp_t);
	endtask : t_rtc_pulse
	task automatic t_radio();
		src_sel = tss_pkg::TSS_SRC_RADIO;
		wait_msg(1'b0, 20);
		check(33'(hit), 33'h1);
		cyc(SETTLE + 5);
		check(33'(synced), 33'h0);
		exp_t = {7'h14, 4'h3, 5'h07, 5'h08, 6'h14, 6'h00};
		src_u.send(0, exp_t);
		check(33'(now_time == exp_t), 33'h0);
		cyc(180 * TICK + 20);
		src_u.send(0, exp_t);
		check(now_time, exp_t);
		wait_msg(1'b1, 3);
		check({hit, intr_stamp[31:0]}, {1'b1, exp_t[31:0]});
		check(intr_stamp, exp_t);
		// Let synced follow so the jump lands in steady sync
		cyc(2);
		offset_min = 11'h03C;
		wait_msg(1'b0, 10);
		check(33'({hit, intr_stamp.hour}), 33'h28);
		wait_msg(1'b1, 3);
		check(33'({hit, intr_stamp.hour}), 33'h29);
	endtask : t_radio
	task automatic t_fault();
		cyc(110 * TICK);
		check(33'(sync_fault), 33'h0);
		cyc(20 * TICK);
		check(33'(sync_fault), 33'h1);
	endtask : t_fault
	task automatic t_irig();
		src_sel = tss_pkg::TSS_SRC_IRIG;
		cyc(SETTLE + 5);
		exp_t = {7'h00, 4'h3, 5'h07, 5'h02, 6'h10, 6'h00};
		src_u.send(1, exp_t);
		exp_t.year = 7'h19;
		exp_t.hour = 5'h03;
		check(now_time, exp_t);
		us_format = 1'b1;
		cyc(2);
		check(33'(date_us), 33'h1);
		src_sel = tss_pkg::TSS_SRC_INTERNAL;
		cyc(SETTLE + 5);
		check(33'(synced), 33'h1);
	endtask : t_irig
	initial begin
		rst = 1'b1;
		rtc_time = {7'h14, 4'h3, 5'h05, 5'h0A, 6'h05, 6'h28};
		src_sel = tss_pkg::TSS_SRC_PULSE;
		irig_year = 7'h19;
		offset_neg = 1'b0;
		offset_min = 11'h000;
		tol_s = 16'h0078;
		us_format = 1'b0;
		repeat (6) @(posedge clk);
		#1;
		rst = 1'b0;
		cyc(1);
		t_rtc_pulse();
		t_radio();
		t_fault();
		t_irig();
		results();
	end
	initial begin
		repeat (6000) @(posedge clk);
		n_mismatch++;
		results();
	end
endmodule : tb_top
bind tss_time_sync_supervisor tss_sva #(.SWITCH_CYCLES(SWITCH_CYCLES)) chk_u (
	.clk(clk), .rst(rst), .src_sel(src_sel), .minute_pulse(minute_pulse),
	.offset_min(offset_min), .us_format(us_format), .now_time(now_time), .synced(synced),
	.intr_on(intr_on), .intr_off(intr_off), .intr_stamp(intr_stamp), .date_us(date_us));
